// File: tb/aiu_host_model.sv
module aiu_host_model (
	input wire i_core_clk,
	input wire i_unpark,
	input wire [15:0] i_err_at,
	input wire i_media_req,
	input wire i_dmarq,
	input wire [15:0] i_dma_data,
	input wire i_unload_req,
	output logic o_parked = 1'b1,
	output logic o_dmack = 1'b0,
	output logic o_valid = 1'b0,
	output logic [15:0] o_data = 16'h0,
	output logic o_err = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Media, heads and slave DMA channel
	logic [15:0] cnt = 16'h0;
	logic slow = 1'b0;
	int n_ok = 0;
	int bad = 0;
	int park_wait = 0;
	logic [15:0] fifo[$];
	// Media answers every other chance; idle bus toggles, not held
	always @(posedge i_core_clk) begin
		slow <= ~slow;
		o_valid <= 1'b0;
		o_err <= 1'b0;
		o_data <= ~o_data;
		if (i_media_req && !o_valid && slow) begin
			o_valid <= 1'b1;
			o_data <= cnt ^ 16'hC3A5;
			o_err <= cnt == i_err_at;
			cnt <= cnt + 16'd1;
			if (cnt != i_err_at) fifo.push_back(cnt ^ 16'hC3A5);
		end
	end
	// Word taken at request; ack held until request drops
	always @(posedge i_core_clk) begin
		if (i_dmarq && !o_dmack) begin
			o_dmack <= 1'b1;
			if (fifo.size() == 0 || i_dma_data !== fifo[0]) bad <= bad + 1;
			else n_ok <= n_ok + 1;
			if (fifo.size() != 0) void'(fifo.pop_front());
		end else if (!i_dmarq) o_dmack <= 1'b0;
	end
	// Ramp reached 30 cycles into a retract; no motion if parked
	always @(posedge i_core_clk) begin
		if (i_unpark) o_parked <= 1'b0;
		if (i_unload_req && !o_parked) park_wait <= park_wait + 1;
		if (park_wait == 30) begin
			o_parked <= 1'b1;
			park_wait <= 0;
		end
	end
endmodule // aiu_host_model

// File: tb/aiu_props.sv
module aiu_props (
	input wire i_core_clk,
	input wire i_reset,
	input wire i_ce,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire i_dmack,
	input wire o_intrq,
	input wire o_dmarq,
	input wire [15:0] o_dma_data,
	input wire o_unload_req,
	input wire o_lookahead_abort,
	input wire o_cache_hold,
	input wire o_low_power_idle,
	input wire o_active_idle,
	input wire o_standby
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Command write seen at the access edge
	wire wr_op = i_psel && i_penable && i_pwrite && i_ce && i_paddr == 8'h18;
	wire [7:0] op = i_pwdata[7:0];
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	// Simple commands are checked three edges after the write
	property p_idle;
		wr_op && (op == 8'h97 || op == 8'hE3) |-> ##3 o_active_idle && !o_standby;
	endproperty
	a_idle: assert property (p_idle) else $error("idle entry");
	property p_idli;
		wr_op && op == 8'h95 |-> ##3 o_intrq && o_active_idle && !o_low_power_idle;
	endproperty
	a_idli: assert property (p_idli) else $error("idle immediate");
	property p_geom;
		wr_op && op == 8'h91 |-> ##3 o_intrq && !o_cache_hold;
	endproperty
	a_geom: assert property (p_geom) else $error("geometry end");
	// Retract, abort and cache hold start together
	property p_unl_go;
		$rose(o_unload_req) |-> o_lookahead_abort && o_cache_hold;
	endproperty
	a_unl_go: assert property (p_unl_go) else $error("unload start");
	property p_unl_end;
		$fell(o_unload_req) |-> o_intrq && o_low_power_idle;
	endproperty
	a_unl_end: assert property (p_unl_end) else $error("unload end");
	property p_pulse;
		o_lookahead_abort |=> !o_lookahead_abort;
	endproperty
	a_pulse: assert property (p_pulse) else $error("abort pulse");
	property p_no_stby;
		o_low_power_idle |-> !o_standby;
	endproperty
	a_no_stby: assert property (p_no_stby) else $error("standby");
	property p_dma_hold;
		o_dmarq && $past(o_dmarq) |-> $stable(o_dma_data);
	endproperty
	a_dma_hold: assert property (p_dma_hold) else $error("dma data");
	// Acknowledge passes a two-stage synchroniser
	property p_dma_ack;
		$rose(i_dmack) && o_dmarq |-> ##[1:5] !o_dmarq;
	endproperty
	a_dma_ack: assert property (p_dma_ack) else $error("dma drop");
endmodule // aiu_props

bind aiu_cmd aiu_props u_props (.i_core_clk, .i_reset, .i_ce, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_dmack, .o_intrq, .o_dmarq,
	.o_dma_data, .o_unload_req, .o_lookahead_abort, .o_cache_hold,
	.o_low_power_idle, .o_active_idle, .o_standby);

// File: tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Design, host model and bus tasks
	logic i_core_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0;
	logic i_pwrite = 0, unpark = 0, slverr, parked, dmack, mvalid, merr;
	logic o_pready, o_pslverr, o_media_req, o_media_lba_mode, o_intrq;
	logic o_dmarq, o_unload_req, o_lookahead_abort, o_cache_hold;
	logic o_low_power_idle, o_active_idle, o_standby;
	logic [7:0] i_paddr = 0, spt;
	logic [3:0] hd;
	logic ce = 1;
	logic [31:0] i_pwdata = 0, o_prdata, rd;
	logic [15:0] mdata, o_dma_data, err_at = 16'hFFFF;
	logic [27:0] o_media_addr, a0;
	logic [7:0] vals[10] = '{0, 1, 240, 241, 251, 252, 253, 254, 255, 0};
	int num_errors = 0, checks_done = 0, irqs = 0;
	aiu_cmd #(.UNIT_CYCLES(20), .UNLOAD_CYCLES(50)) uut (.i_core_clk,
		.i_reset, .i_ce(ce), .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_heads_parked(parked),
		.i_dmack(dmack), .i_media_valid(mvalid), .i_media_data(mdata),
		.i_media_err(merr), .o_media_req, .o_media_addr, .o_media_lba_mode,
		.o_intrq, .o_dmarq, .o_dma_data, .o_unload_req, .o_lookahead_abort,
		.o_cache_hold, .o_low_power_idle, .o_active_idle, .o_standby);
	aiu_host_model pm (.i_core_clk, .i_unpark(unpark), .i_err_at(err_at),
		.i_media_req(o_media_req), .i_dmarq(o_dmarq), .i_dma_data(o_dma_data),
		.i_unload_req(o_unload_req), .o_parked(parked), .o_dmack(dmack),
		.o_valid(mvalid), .o_data(mdata), .o_err(merr));
	initial forever #25 i_core_clk = ~i_core_clk;
	// Each interrupt edge counted
	always @(posedge o_intrq) irqs++;
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge i_core_clk);
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
		@(posedge i_core_clk);
		i_penable <= 1;
		do @(posedge i_core_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		slverr = o_pslverr;
		{i_psel, i_penable} <= 2'b00;
	endtask
	task automatic tf(logic [7:0] f, c, l, m, h, dh);
		logic [7:0] v[6];
		v = '{f, c, l, m, h, dh};
		for (int i = 0; i < 6; i++) apb(1, 8'(4 * i), {24'h0, v[i]});
	endtask
	// Bounded wait for interrupt, then status read clears it
	task automatic irq(int lim);
		int n;
		n = 0;
		while (o_intrq !== 1'b1 && n < lim) begin
			@(posedge i_core_clk);
			n++;
		end
		chk("intrq", 1, o_intrq);
		apb(0, 8'h18, 0);
	endtask
	task automatic cmd(logic [7:0] op, int lim);
		apb(1, 8'h18, {24'h0, op});
		irq(lim);
	endtask
	// Timer field {enable, units of five seconds}; 30 min is 360 units
	function automatic logic [31:0] tmr_exp(logic [7:0] c);
		if (c == 0) return 32'h0;
		if (c <= 240) return {24'h2, c};
		if (c == 252) return 32'h2FC;
		if (c >= 254) return 32'h2FF;
		return 32'h368;
	endfunction
	task automatic print_verdict;
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog well beyond the longest expected run
	initial begin
		#4000000;
		num_errors++;
		print_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'hB8445F47));
		vals[9] = 8'($urandom_range(240, 1));
		repeat (2) @(posedge i_core_clk);
		i_reset <= 0;
		apb(0, 8'h28, 0);
		chk("timer_rst", 0, rd);
		foreach (vals[i]) begin
			tf(0, vals[i], 1, 0, 0, 0);
			cmd(i[0] ? 8'hE3 : 8'h97, 8);
			apb(0, 8'h28, 0);
			chk("timer", tmr_exp(vals[i]), rd);
		end
		tf(0, 1, 1, 0, 0, 0);
		cmd(8'h97, 8);
		// Enable low: the standby count must not advance
		ce <= 0;
		repeat (40) @(posedge i_core_clk);
		chk("frozen", 0, o_standby);
		ce <= 1;
		repeat (40) @(posedge i_core_clk);
		chk("standby", 1, o_standby);
		tf(8'h44, 0, 8'h4C, 8'h4E, 8'h00, 0);
		cmd(8'hE1, 8);
		chk("partial", 2'b01, {o_unload_req, o_active_idle});
		cmd(8'h95, 8);
		unpark <= 1;
		tf(8'h44, 0, 8'h4C, 8'h4E, 8'h55, 0);
		unpark <= 0;
		apb(1, 8'h18, 32'hE1);
		repeat (6) @(posedge i_core_clk);
		chk("retract", 2'b10, {o_unload_req, o_intrq});
		irq(200);
		chk("low_power", 2'b11, {o_low_power_idle, o_cache_hold});
		apb(0, 8'h20, 0);
		chk("late", 0, rd[4]);
		repeat (100) @(posedge i_core_clk);
		chk("no_standby", 0, o_standby);
		tf(8'h44, 0, 8'h4C, 8'h4E, 8'h55, 0);
		cmd(8'hE1, 3);
		chk("parked", 2'b01, {o_unload_req, o_cache_hold});
		spt = 8'($urandom_range(255, 2));
		hd = 4'($urandom);
		tf(0, spt, 0, 0, 0, {4'hA, hd});
		cmd(8'h91, 4);
		apb(0, 8'h24, 0);
		chk("geom", {20'h0, hd, spt}, rd);
		chk("cache_free", 0, o_cache_hold);
		cmd(8'hE4, 4);
		chk("drq", 1, rd[3]);
		repeat (256) apb(0, 8'h1C, 0);
		apb(0, 8'h18, 0);
		chk("drq_end", 0, rd[3]);
		a0 = 28'($urandom);
		tf(0, 2, a0[7:0], a0[15:8], a0[23:16], {4'hE, a0[27:24]});
		irqs = 0;
		apb(1, 8'h18, 32'hC8);
		repeat (8) @(posedge i_core_clk);
		chk("lba_addr", {1'b1, a0}, {o_media_lba_mode, o_media_addr});
		irq(20000);
		chk("irq_count", 1, irqs);
		chk("words", 512, pm.n_ok);
		chk("word_bad", 0, pm.bad);
		// Buffer now holds the last DMA sector
		cmd(8'hE4, 4);
		for (int i = 0; i < 256; i++) begin
			apb(0, 8'h1C, 0);
			chk("buf_word", 16'(i + 256) ^ 16'hC3A5, rd);
		end
		err_at <= pm.cnt + 16'd259;
		tf(0, 3, 1, a0[7:0], a0[15:8], {4'hA, hd});
		cmd(8'hC9, 20000);
		chk("dma_err", 16'h4041, rd[15:0]);
		chk("words2", 771, pm.n_ok);
		chk("chs", 0, o_media_lba_mode);
		apb(0, 8'h08, 0);
		chk("fail_sector", 2, rd);
		apb(0, 8'h0C, 0);
		chk("fail_cyl", {24'h0, a0[7:0]}, rd);
		apb(0, 8'h40, 0);
		chk("slverr", 1, slverr);
		chk("unmapped", 0, rd);
		i_reset <= 1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 0;
		apb(0, 8'h28, 0);
		chk("timer_rst2", 0, rd);
		apb(0, 8'h18, 0);
		chk("status_rst", 32'h40, rd);
		apb(0, 8'h04, 0);
		chk("count_rst", 1, rd);
		print_verdict();
	end
endmodule // tb_top

// File: verilog/aiu_cmd.v
`include "aiu_defines.vh"

module aiu_cmd #(
	parameter UNIT_CYCLES = `AIU_CLK_HZ * `AIU_UNIT_SEC,
	parameter UNLOAD_CYCLES = `AIU_CLK_HZ / 1000 * `AIU_UNLOAD_MS
) (
	input wire i_core_clk,
	input wire i_reset,
	input wire i_ce,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [7:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	input wire i_heads_parked,
	input wire i_dmack,
	input wire i_media_valid,
	input wire [15:0] i_media_data,
	input wire i_media_err,
	output wire o_media_req,
	output wire [27:0] o_media_addr,
	output wire o_media_lba_mode,
	output reg o_intrq,
	output reg o_dmarq,
	output reg [15:0] o_dma_data,
	output wire o_unload_req,
	output reg o_lookahead_abort,
	output reg o_cache_hold,
	output reg o_low_power_idle,
	output reg o_active_idle,
	output reg o_standby
);

// ==========================================================
// States
localparam [4:0] S_RDY = 5'b00001;
localparam [4:0] S_DEC = 5'b00010;
localparam [4:0] S_UNL = 5'b00100;
localparam [4:0] S_GET = 5'b01000;
localparam [4:0] S_PUT = 5'b10000;

reg [4:0] state_reg;
reg [7:0] feat_reg, count_reg, alow_reg, amid_reg, ahigh_reg;
reg [7:0] dsh_reg, op_reg, err_reg;
reg bsy_reg, drq_reg;
reg [7:0] spt_reg;
reg [3:0] heads_reg;
reg tmr_en_reg;
reg [8:0] tmr_units_reg, unit_cnt_reg;
reg [26:0] pre_cnt_reg;
reg [23:0] unl_cnt_reg;
reg unl_late_reg;
reg [8:0] secs_left_reg;
reg [7:0] wcnt_reg, ptr_reg;
reg [15:0] sbuf [0:255];
reg park_s1, park_s2, ack_s1, ack_s2, ack_d;

// ==========================================================
// Functions
function [8:0] stby_units;
	input [7:0] sc;
	begin
		if (sc <= 8'hF0)
			stby_units = {1'b0, sc};
		else if (sc == 8'hFC)
			stby_units = `AIU_TMR_21MIN;
		else if (sc >= 8'hFE)
			stby_units = `AIU_TMR_21M15;
		else
			stby_units = `AIU_TMR_30MIN;
	end
endfunction

// Next CHS or LBA address after a good sector
function [27:0] next_addr;
	input lba;
	input [27:0] a;
	input [7:0] spt;
	input [3:0] hd;
	begin
		if (lba) begin
			next_addr = a + 28'h0000001;
		end else if (a[7:0] < spt) begin
			next_addr = {a[27:8], a[7:0] + 8'h01};
		end else if (a[27:24] < hd) begin
			next_addr = {a[27:24] + 4'h1, a[23:8], 8'h01};
		end else begin
			next_addr = {4'h0, a[23:8] + 16'h0001, 8'h01};
		end
	end
endfunction

// ==========================================================
// Bus decode
wire wr_acc = i_psel & i_penable & i_pwrite;
wire rd_acc = i_psel & i_penable & ~i_pwrite;
wire a_feat = i_paddr == `AIU_OFS_FEAT;
wire a_cnt = i_paddr == `AIU_OFS_COUNT;
wire a_low = i_paddr == `AIU_OFS_ALOW;
wire a_mid = i_paddr == `AIU_OFS_AMID;
wire a_high = i_paddr == `AIU_OFS_AHIGH;
wire a_dsh = i_paddr == `AIU_OFS_DSH;
wire a_cmd = i_paddr == `AIU_OFS_CMD;
wire a_data = i_paddr == `AIU_OFS_DATA;
wire a_ctrl = i_paddr == `AIU_OFS_CTRL;
wire a_geom = i_paddr == `AIU_OFS_GEOM;
wire a_tmr = i_paddr == `AIU_OFS_TIMER;
wire mapped = a_feat | a_cnt | a_low | a_mid | a_high | a_dsh |
	a_cmd | a_data | a_ctrl | a_geom | a_tmr;

// Ready follows enable so a frozen core loses no write
assign o_pready = i_ce;
assign o_pslverr = i_psel & i_penable & ~mapped;

wire tf_wr = wr_acc & ~bsy_reg;
wire cmd_wr = tf_wr & a_cmd;
wire srst = i_ce & wr_acc & a_ctrl & i_pwdata[`AIU_CTRL_SRST];
wire stat_rd = rd_acc & a_cmd;
wire data_rd = rd_acc & a_data & drq_reg & ~o_dmarq;
wire dack_rise = ack_s2 & ~ack_d;

wire is_lba = dsh_reg[`AIU_DSH_LBA];
wire [27:0] cur_addr = {dsh_reg[3:0], ahigh_reg, amid_reg, alow_reg};
wire [27:0] nxt = next_addr(is_lba, cur_addr, spt_reg, heads_reg);
wire sig_ok = op_reg == `AIU_OP_IDLI_B && feat_reg == `AIU_SIG_FEAT &&
	alow_reg == `AIU_SIG_LOW && amid_reg == `AIU_SIG_MID &&
	ahigh_reg == `AIU_SIG_HIGH && count_reg == `AIU_SIG_COUNT;

assign o_media_req = state_reg == S_GET;
assign o_media_addr = cur_addr;
assign o_media_lba_mode = is_lba;
assign o_unload_req = state_reg == S_UNL;

// ==========================================================
// Pin synchronisers; only the second stage is used
always @(posedge i_core_clk) begin
	if (i_reset) begin
		park_s1 <= 1'b0;
		park_s2 <= 1'b0;
		ack_s1 <= 1'b0;
		ack_s2 <= 1'b0;
		ack_d <= 1'b0;
	end else if (i_ce) begin
		park_s1 <= i_heads_parked;
		park_s2 <= park_s1;
		ack_s1 <= i_dmack;
		ack_s2 <= ack_s1;
		ack_d <= ack_s2;
	end
end

// ==========================================================
// Read data, captured while the transfer is in setup
always @(posedge i_core_clk) begin
	if (i_reset) begin
		o_prdata <= 32'h00000000;
	end else if (i_ce && i_psel && !i_penable) begin
		o_prdata <= 32'h00000000;
		if (a_cnt)
			o_prdata[7:0] <= count_reg;
		if (a_low)
			o_prdata[7:0] <= alow_reg;
		if (a_mid)
			o_prdata[7:0] <= amid_reg;
		if (a_high)
			o_prdata[7:0] <= ahigh_reg;
		if (a_dsh)
			o_prdata[7:0] <= dsh_reg;
		if (a_cmd)
			o_prdata[15:0] <= {err_reg, bsy_reg, ~bsy_reg, 2'b00,
				drq_reg, 2'b00, |err_reg};
		if (a_data)
			o_prdata[15:0] <= sbuf[ptr_reg];
		if (a_ctrl)
			o_prdata[4:0] <= {unl_late_reg, o_low_power_idle,
				o_active_idle, o_standby, o_cache_hold};
		if (a_geom)
			o_prdata[11:0] <= {heads_reg, spt_reg};
		if (a_tmr)
			o_prdata[9:0] <= {tmr_en_reg, tmr_units_reg};
	end
end

// ==========================================================
// Sector buffer, filled by the DMA path and drained by reads
always @(posedge i_core_clk) begin
	if (i_ce && state_reg == S_GET && i_media_valid && !i_media_err)
		sbuf[wcnt_reg] <= i_media_data;
end

// ==========================================================
// Standby timer; frozen while busy or parked after unload
always @(posedge i_core_clk) begin
	if (i_reset || srst) begin
		pre_cnt_reg <= 27'h0000000;
		unit_cnt_reg <= 9'h000;
		o_standby <= 1'b0;
	end else if (i_ce) begin
		if (cmd_wr) begin
			pre_cnt_reg <= 27'h0000000;
			unit_cnt_reg <= 9'h000;
			o_standby <= 1'b0;
		end else if (tmr_en_reg && o_active_idle && !bsy_reg &&
				!o_low_power_idle) begin
			if (pre_cnt_reg == UNIT_CYCLES[26:0] - 27'h0000001) begin
				pre_cnt_reg <= 27'h0000000;
				if (unit_cnt_reg == tmr_units_reg - 9'h001)
					o_standby <= 1'b1;
				else
					unit_cnt_reg <= unit_cnt_reg + 9'h001;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + 27'h0000001;
			end
		end
	end
end

// ==========================================================
// Command engine
always @(posedge i_core_clk) begin
	if (i_reset || srst) begin
		state_reg <= S_RDY;
		feat_reg <= 8'h00;
		count_reg <= 8'h01;
		alow_reg <= 8'h01;
		amid_reg <= 8'h00;
		ahigh_reg <= 8'h00;
		dsh_reg <= 8'h00;
		op_reg <= 8'h00;
		err_reg <= 8'h00;
		bsy_reg <= 1'b0;
		drq_reg <= 1'b0;
		spt_reg <= 8'h00;
		heads_reg <= 4'h0;
		tmr_en_reg <= 1'b0;
		tmr_units_reg <= 9'h000;
		unl_cnt_reg <= 24'h000000;
		unl_late_reg <= 1'b0;
		secs_left_reg <= 9'h000;
		wcnt_reg <= 8'h00;
		ptr_reg <= 8'h00;
		o_intrq <= 1'b0;
		o_dmarq <= 1'b0;
		o_dma_data <= 16'h0000;
		o_lookahead_abort <= 1'b0;
		o_cache_hold <= 1'b0;
		o_low_power_idle <= 1'b0;
		o_active_idle <= 1'b1;
	end else if (i_ce) begin
		o_lookahead_abort <= 1'b0;
		// Status read acknowledges the interrupt
		if (stat_rd)
			o_intrq <= 1'b0;
		// Task file writes are ignored while busy
		if (tf_wr && a_feat)
			feat_reg <= i_pwdata[7:0];
		if (tf_wr && a_cnt)
			count_reg <= i_pwdata[7:0];
		if (tf_wr && a_low)
			alow_reg <= i_pwdata[7:0];
		if (tf_wr && a_mid)
			amid_reg <= i_pwdata[7:0];
		if (tf_wr && a_high)
			ahigh_reg <= i_pwdata[7:0];
		if (tf_wr && a_dsh)
			dsh_reg <= i_pwdata[7:0];
		// Buffer port read; a full sector ends the transfer
		if (data_rd) begin
			ptr_reg <= ptr_reg + 8'h01;
			if (ptr_reg == 8'hFF)
				drq_reg <= 1'b0;
		end
		case (state_reg)
		S_RDY: begin
			if (cmd_wr) begin
				op_reg <= i_pwdata[7:0];
				bsy_reg <= 1'b1;
				drq_reg <= 1'b0;
				err_reg <= 8'h00;
				o_intrq <= 1'b0;
				state_reg <= S_DEC;
			end
		end
		S_DEC: begin
			// Anything but a repeat unload releases held cache
			if (!sig_ok) begin
				o_cache_hold <= 1'b0;
				o_low_power_idle <= 1'b0;
			end
			state_reg <= S_RDY;
			bsy_reg <= 1'b0;
			o_intrq <= 1'b1;
			case (op_reg)
			`AIU_OP_IDLE_A, `AIU_OP_IDLE_B: begin
				o_active_idle <= 1'b1;
				tmr_en_reg <= count_reg != 8'h00;
				tmr_units_reg <= stby_units(count_reg);
			end
			`AIU_OP_IDLI_A, `AIU_OP_IDLI_B: begin
				o_active_idle <= 1'b1;
				if (sig_ok) begin
					o_active_idle <= 1'b0;
					o_lookahead_abort <= 1'b1;
					o_cache_hold <= 1'b1;
					unl_cnt_reg <= 24'h000000;
					unl_late_reg <= 1'b0;
					if (park_s2) begin
						o_low_power_idle <= 1'b1;
					end else begin
						bsy_reg <= 1'b1;
						o_intrq <= 1'b0;
						state_reg <= S_UNL;
					end
				end
			end
			`AIU_OP_GEOM: begin
				spt_reg <= count_reg;
				heads_reg <= dsh_reg[3:0];
			end
			`AIU_OP_RDBUF: begin
				ptr_reg <= 8'h00;
				drq_reg <= 1'b1;
			end
			`AIU_OP_DMA_A, `AIU_OP_DMA_B: begin
				// Zero count means 256 sectors
				secs_left_reg <= (count_reg == 8'h00) ? 9'h100 :
					{1'b0, count_reg};
				wcnt_reg <= 8'h00;
				drq_reg <= 1'b1;
				bsy_reg <= 1'b1;
				o_intrq <= 1'b0;
				state_reg <= S_GET;
			end
			default: begin
				err_reg <= `AIU_ERR_ABRT;
			end
			endcase
		end
		S_UNL: begin
			// Late flag only; the command still waits for the latch
			if (unl_cnt_reg == UNLOAD_CYCLES[23:0] - 24'h000001)
				unl_late_reg <= 1'b1;
			else
				unl_cnt_reg <= unl_cnt_reg + 24'h000001;
			if (park_s2) begin
				bsy_reg <= 1'b0;
				o_intrq <= 1'b1;
				o_low_power_idle <= 1'b1;
				state_reg <= S_RDY;
			end
		end
		S_GET: begin
			if (i_media_valid) begin
				if (i_media_err) begin
					// Address registers keep the failing sector
					err_reg <= `AIU_ERR_UNC;
					drq_reg <= 1'b0;
					bsy_reg <= 1'b0;
					o_intrq <= 1'b1;
					state_reg <= S_RDY;
				end else begin
					o_dma_data <= i_media_data;
					o_dmarq <= 1'b1;
					state_reg <= S_PUT;
				end
			end
		end
		S_PUT: begin
			if (dack_rise) begin
				o_dmarq <= 1'b0;
				wcnt_reg <= wcnt_reg + 8'h01;
				state_reg <= S_GET;
				if (wcnt_reg == 8'hFF) begin
					secs_left_reg <= secs_left_reg - 9'h001;
					if (secs_left_reg == 9'h001) begin
						drq_reg <= 1'b0;
						bsy_reg <= 1'b0;
						o_intrq <= 1'b1;
						state_reg <= S_RDY;
					end else begin
						{dsh_reg[3:0], ahigh_reg, amid_reg,
							alow_reg} <= nxt;
					end
				end
			end
		end
		default: begin
			state_reg <= S_RDY;
		end
		endcase
	end
end

endmodule // aiu_cmd

// File: verilog/aiu_defines.vh
// Overview of operation
// - Idle opcodes: active idle, load standby timer
// - Timer off at reset and count zero
// - Counts 1..240 give count times five seconds
// - 241-251,253: 30 min; 252: 21; 254-255: 21:15
// - Idle immediate: active idle, clear busy, interrupt
// - Full parameter signature selects head unload variant
// - Unload starts head retract at once
// - Unload interrupt only after heads parked, latched
// - Unload normally completes within 500 ms
// - Unload aborts look-ahead, suspends cache writes
// - Cache kept until reset or other command
// - After unload: low power, no standby, no load
// - Already parked: no motion, still complete
// - Geometry: busy, store, clear busy, interrupt
// - Sectors from count, heads from low nibble
// - Geometry never validated when stored
// - Read buffer: busy, prepare, data request, interrupt
// - Mode bit picks CHS or 28-bit LBA
// - DMA words qualified by request, host acknowledge
// - Exactly one interrupt per read DMA
// - Error stops DMA, failing address kept
`ifndef AIU_DEFINES_VH
`define AIU_DEFINES_VH
// ==========================================================
// Register byte offsets
`define AIU_OFS_FEAT 8'h00
`define AIU_OFS_COUNT 8'h04
`define AIU_OFS_ALOW 8'h08
`define AIU_OFS_AMID 8'h0C
`define AIU_OFS_AHIGH 8'h10
`define AIU_OFS_DSH 8'h14
`define AIU_OFS_CMD 8'h18
`define AIU_OFS_DATA 8'h1C
`define AIU_OFS_CTRL 8'h20
`define AIU_OFS_GEOM 8'h24
`define AIU_OFS_TIMER 8'h28
// ==========================================================
// Opcodes and unload signature
`define AIU_OP_IDLE_A 8'h97
`define AIU_OP_IDLE_B 8'hE3
`define AIU_OP_IDLI_A 8'h95
`define AIU_OP_IDLI_B 8'hE1
`define AIU_OP_GEOM 8'h91
`define AIU_OP_RDBUF 8'hE4
`define AIU_OP_DMA_A 8'hC8
`define AIU_OP_DMA_B 8'hC9
`define AIU_SIG_FEAT 8'h44
`define AIU_SIG_LOW 8'h4C
`define AIU_SIG_MID 8'h4E
`define AIU_SIG_HIGH 8'h55
`define AIU_SIG_COUNT 8'h00
// ==========================================================
// Field positions and values
`define AIU_DSH_LBA 6
`define AIU_CTRL_SRST 2
`define AIU_ERR_ABRT 8'h04
`define AIU_ERR_UNC 8'h40
`define AIU_TMR_30MIN 9'h168
`define AIU_TMR_21MIN 9'h0FC
`define AIU_TMR_21M15 9'h0FF
// ==========================================================
// Timing
`define AIU_CLK_HZ 20000000
`define AIU_UNIT_SEC 5
`define AIU_UNLOAD_MS 500
`endif
